// ---- pkg/cdsu_defs.vh ----
/*
 * constants for the clock divider and status unit: register offsets,
 * field positions and reset values.
 * assumes a plain byte-addressed register port with 8-bit addresses.
 */
// Operation
// - master divider codes give 1,2,4,6
// - processor divider bit gives 1 or 2
// - master code zero forces processor bit zero
// - output source: slow, main, pll1, pll2
// - prescaler 1,2,4,8,16,32,64; code 111 reserved
// - enable write ones set mask bits
// - disable write ones clear mask bits
// - mask register shows enabled interrupts
// - bit 0 shows oscillator stable
// - bits 1,2 show pll locks
// - bit 3 shows master clock ready
// - bit 7 shows slow source choice
// - bits 8,9 show programmable clocks ready
// - oscillator stable after start-up count elapses
// - pll lock after programmed count elapses
`ifndef CDSU_DEFS_VH
`define CDSU_DEFS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CDSU_OSC_CTRL 8'h00
`define CDSU_PLL1_CFG 8'h04
`define CDSU_PLL2_CFG 8'h08
`define CDSU_MCK_CFG 8'h0c
`define CDSU_PCK0_CFG 8'h10
`define CDSU_PCK1_CFG 8'h14
`define CDSU_IRQ_EN 8'h18
`define CDSU_IRQ_DIS 8'h1c
`define CDSU_STATUS 8'h20
`define CDSU_IRQ_MASK 8'h24
`define CDSU_PUMP 8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CDSU_OSC_EN_BIT 0
`define CDSU_OSC_CNT_LSB 8
`define CDSU_PLL_CNT_LSB 8
`define CDSU_MASTER_CLOCK_DIVIDER_LSB 8
`define CDSU_PROCESSOR_CLOCK_DIVIDER_BIT 12
`define CDSU_PUMP1_BIT 0
`define CDSU_PUMP2_BIT 16
`define CDSU_SLOW_SEL_BIT 7
`define CDSU_STAT_MASK 10'h30f
`define CDSU_OSC_MULT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDSU_MCK_RST 5'h01
`define CDSU_PCK_RST 5'h00

`endif

// ---- core/cdsu_clock_unit.v ----
/*
 * clock divider and status unit: master/processor dividers, two
 * programmable output clocks, status flags with enable/disable/mask,
 * and a write-only charge-pump setting.
 * assumes clock sources arrive as pins from outside clk_sys and are
 * far slower than clk_sys; software uses the plain register port.
 */
`timescale 1ns/10ps
`include "cdsu_defs.vh"

module cdsu_clock_unit #(
    parameter CNT_W = 6
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire slow_clk_in,
    input wire main_clk_in,
    input wire pll1_clk_in,
    input wire pll2_clk_in,
    input wire slow_source_choice,
    output reg master_clk,
    output reg processor_clk,
    output reg [1:0] prog_clk,
    output reg [1:0] first_pll_pump_current_out,
    output wire irq
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [4:0] pin_s1_r; // first stage, read only by second
reg [4:0] pin_s2_r; // usable copies
reg slow_d_r; // slow clock, previous sample
wire [3:0] src_s = pin_s2_r[3:0]; // slow, main, pll1, pll2
wire slow_sel_s = pin_s2_r[4];
wire slow_tick = src_s[0] & ~slow_d_r;

// sync all asynchronous pins before any logic sees them
always @(posedge clk_sys) begin
    if (!rst_n) begin
        pin_s1_r <= 5'h00;
        pin_s2_r <= 5'h00;
        slow_d_r <= 1'b0;
    end else if (clk_en) begin
        pin_s1_r <= {slow_source_choice, pll2_clk_in, pll1_clk_in,
                     main_clk_in, slow_clk_in};
        pin_s2_r <= pin_s1_r;
        slow_d_r <= pin_s2_r[0];
    end
end

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// prescaler code to half-period in source edges
function [6:0] cdsu_output_divider_select_div;
    input [2:0] code;
    begin
        case (code)
            3'h0: cdsu_output_divider_select_div = 7'h01;
            3'h1: cdsu_output_divider_select_div = 7'h02;
            3'h2: cdsu_output_divider_select_div = 7'h04;
            3'h3: cdsu_output_divider_select_div = 7'h08;
            3'h4: cdsu_output_divider_select_div = 7'h10;
            3'h5: cdsu_output_divider_select_div = 7'h20;
            3'h6: cdsu_output_divider_select_div = 7'h40;
            default: cdsu_output_divider_select_div = 7'h00; // reserved: output stops
        endcase
    end
endfunction

// pick one source level from the 2-bit selector
function cdsu_pick;
    input [1:0] sel;
    input [3:0] src;
    begin
        cdsu_pick = src[sel];
    end
endfunction

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg osc_en_r; // main oscillator enable
reg [7:0] osc_cnt_r; // start-up count, slow clocks x8
reg [CNT_W-1:0] pll1_cnt_r; // first pll lock count
reg [CNT_W-1:0] pll2_cnt_r; // second pll lock count
reg [1:0] mck_css_r;
reg [2:0] mck_output_divider_select_r;
reg [1:0] master_clock_divider_r; // master_clock_divider
reg processor_clock_divider_r; // processor_clock_divider
reg [4:0] pck_cfg_r [0:1]; // {output_divider_select, clock_source_select}
reg [9:0] mask_r; // interrupt mask
reg [10:0] osc_tmr_r; // start-up counter, wide enough for 255 x 8
reg [CNT_W-1:0] pll1_tmr_r;
reg [CNT_W-1:0] pll2_tmr_r;
reg mosc_ok_r;
reg lock1_r;
reg lock2_r;
reg mck_rdy_r;
reg [1:0] pck_rdy_r;
reg [3:0] rdy_tmr_r; // settle delay after clock change

wire wr_hit_mck = reg_wr && reg_addr == `CDSU_MCK_CFG;
wire [9:0] status = {pck_rdy_r, 4'h0, mck_rdy_r, lock2_r, lock1_r, mosc_ok_r};
wire [31:0] status_word = {22'h0, status[9:8], slow_sel_s, 3'h0, status[3:0]};

// write decode and register state
always @(posedge clk_sys) begin
    if (!rst_n) begin
        osc_en_r <= 1'b0;
        osc_cnt_r <= 8'h00;
        pll1_cnt_r <= {CNT_W{1'b0}};
        pll2_cnt_r <= {CNT_W{1'b0}};
        {mck_output_divider_select_r, mck_css_r} <= `CDSU_MCK_RST;
        master_clock_divider_r <= 2'h0;
        processor_clock_divider_r <= 1'b0;
        pck_cfg_r[0] <= `CDSU_PCK_RST;
        pck_cfg_r[1] <= `CDSU_PCK_RST;
        mask_r <= 10'h000;
        first_pll_pump_current_out <= 2'h0;
    end else if (clk_en && reg_wr) begin
        case (reg_addr)
            `CDSU_OSC_CTRL: begin
                osc_en_r <= reg_wdata[`CDSU_OSC_EN_BIT];
                osc_cnt_r <= reg_wdata[`CDSU_OSC_CNT_LSB +: 8];
            end
            `CDSU_PLL1_CFG: pll1_cnt_r <= reg_wdata[`CDSU_PLL_CNT_LSB +: CNT_W];
            `CDSU_PLL2_CFG: pll2_cnt_r <= reg_wdata[`CDSU_PLL_CNT_LSB +: CNT_W];
            `CDSU_MCK_CFG: begin
                {mck_output_divider_select_r, mck_css_r} <= reg_wdata[4:0];
                master_clock_divider_r <= reg_wdata[`CDSU_MASTER_CLOCK_DIVIDER_LSB +: 2];
                // a zero master divide ignores the processor bit
                processor_clock_divider_r <= (reg_wdata[`CDSU_MASTER_CLOCK_DIVIDER_LSB +: 2] == 2'h0) ? 1'b0 :
                          reg_wdata[`CDSU_PROCESSOR_CLOCK_DIVIDER_BIT];
            end
            `CDSU_PCK0_CFG: pck_cfg_r[0] <= reg_wdata[4:0];
            `CDSU_PCK1_CFG: pck_cfg_r[1] <= reg_wdata[4:0];
            `CDSU_IRQ_EN: mask_r <= mask_r | (reg_wdata[9:0] & `CDSU_STAT_MASK);
            `CDSU_IRQ_DIS: mask_r <= mask_r & ~(reg_wdata[9:0] & `CDSU_STAT_MASK);
            `CDSU_PUMP: begin
                // bit 16 stored as written; software must keep it zero
                first_pll_pump_current_out <= {reg_wdata[`CDSU_PUMP2_BIT],
                                               reg_wdata[`CDSU_PUMP1_BIT]};
            end
            default: ;
        endcase
    end
end

// read port: data in the cycle after the strobe
always @(posedge clk_sys) begin
    if (!rst_n) begin
        reg_rdata <= 32'h0;
    end else if (clk_en) begin
        reg_rdata <= 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `CDSU_OSC_CTRL: reg_rdata <= {16'h0, osc_cnt_r, 7'h0, osc_en_r};
                `CDSU_PLL1_CFG: reg_rdata <= {{(32-CNT_W){1'b0}}, pll1_cnt_r} << `CDSU_PLL_CNT_LSB;
                `CDSU_PLL2_CFG: reg_rdata <= {{(32-CNT_W){1'b0}}, pll2_cnt_r} << `CDSU_PLL_CNT_LSB;
                `CDSU_MCK_CFG: reg_rdata <= {19'h0, processor_clock_divider_r, 2'h0, master_clock_divider_r,
                                             3'h0, mck_output_divider_select_r, mck_css_r};
                `CDSU_PCK0_CFG: reg_rdata <= {27'h0, pck_cfg_r[0]};
                `CDSU_PCK1_CFG: reg_rdata <= {27'h0, pck_cfg_r[1]};
                `CDSU_STATUS: reg_rdata <= status_word;
                `CDSU_IRQ_MASK: reg_rdata <= {22'h0, mask_r};
                default: reg_rdata <= 32'h0; // unmapped and write-only read zero
            endcase
        end
    end
end

// ----------------------------------------------------------------
// start-up and lock timers, counted on slow clock edges
// ----------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        osc_tmr_r <= 11'h000;
        mosc_ok_r <= 1'b0;
        pll1_tmr_r <= {CNT_W{1'b0}};
        pll2_tmr_r <= {CNT_W{1'b0}};
        lock1_r <= 1'b0;
        lock2_r <= 1'b0;
    end else if (clk_en) begin
        // oscillator: count 8 x programmed slow periods after enable
        if (!osc_en_r) begin
            osc_tmr_r <= 11'h000;
            mosc_ok_r <= 1'b0;
        end else if (slow_tick && !mosc_ok_r) begin
            if (osc_tmr_r >= ({3'h0, osc_cnt_r} << `CDSU_OSC_MULT))
                mosc_ok_r <= 1'b1;
            else
                osc_tmr_r <= osc_tmr_r + 11'h001;
        end
        // a config write restarts the lock wait
        if (reg_wr && reg_addr == `CDSU_PLL1_CFG) begin
            pll1_tmr_r <= {CNT_W{1'b0}};
            lock1_r <= 1'b0;
        end else if (slow_tick && !lock1_r) begin
            if (pll1_tmr_r >= pll1_cnt_r)
                lock1_r <= 1'b1;
            else
                pll1_tmr_r <= pll1_tmr_r + 1'b1;
        end
        if (reg_wr && reg_addr == `CDSU_PLL2_CFG) begin
            pll2_tmr_r <= {CNT_W{1'b0}};
            lock2_r <= 1'b0;
        end else if (slow_tick && !lock2_r) begin
            if (pll2_tmr_r >= pll2_cnt_r)
                lock2_r <= 1'b1;
            else
                pll2_tmr_r <= pll2_tmr_r + 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// dividers: edge-counted, outputs toggle from flip-flops
// ----------------------------------------------------------------
reg src_d_r; // master source, previous sample
reg [6:0] output_divider_select_cnt_r;
reg output_divider_select_tick_r; // one pulse per prescaler half-period
reg [2:0] master_clock_divider_cnt_r;
reg processor_clock_divider_cnt_r;
reg [1:0] pk_d_r;
reg [6:0] pk_cnt_r [0:1];
wire mck_src = cdsu_pick(mck_css_r, src_s);
wire [6:0] mck_div = cdsu_output_divider_select_div(mck_output_divider_select_r);
// master divide as half-periods of prescaler output: 1,2,4,6
wire [2:0] master_clock_divider_half = (master_clock_divider_r == 2'h0) ? 3'h1 : (master_clock_divider_r == 2'h1) ? 3'h2 :
                       (master_clock_divider_r == 2'h2) ? 3'h4 : 3'h6;
integer k;

// master and processor clock generation
always @(posedge clk_sys) begin
    if (!rst_n) begin
        src_d_r <= 1'b0;
        output_divider_select_cnt_r <= 7'h00;
        output_divider_select_tick_r <= 1'b0;
        master_clock_divider_cnt_r <= 3'h0;
        processor_clock_divider_cnt_r <= 1'b0;
        master_clk <= 1'b0;
        processor_clk <= 1'b0;
    end else if (clk_en) begin
        src_d_r <= mck_src;
        output_divider_select_tick_r <= 1'b0;
        // count both source edges, so half-period counts stay exact
        if (mck_src != src_d_r && mck_div != 7'h00) begin
            if (output_divider_select_cnt_r + 7'h01 >= mck_div) begin
                output_divider_select_cnt_r <= 7'h00;
                output_divider_select_tick_r <= 1'b1;
            end else begin
                output_divider_select_cnt_r <= output_divider_select_cnt_r + 7'h01;
            end
        end
        if (output_divider_select_tick_r) begin
            if (master_clock_divider_cnt_r + 3'h1 >= master_clock_divider_half) begin
                master_clock_divider_cnt_r <= 3'h0;
                master_clk <= ~master_clk;
            end else begin
                master_clock_divider_cnt_r <= master_clock_divider_cnt_r + 3'h1;
            end
            // processor: toggle every tick, or every second one
            if (processor_clock_divider_r) begin
                processor_clock_divider_cnt_r <= ~processor_clock_divider_cnt_r;
                if (processor_clock_divider_cnt_r)
                    processor_clk <= ~processor_clk;
            end else begin
                processor_clk <= ~processor_clk;
            end
        end
    end
end

// programmable clocks
always @(posedge clk_sys) begin
    if (!rst_n) begin
        pk_d_r <= 2'h0;
        pk_cnt_r[0] <= 7'h00;
        pk_cnt_r[1] <= 7'h00;
        prog_clk <= 2'h0;
    end else if (clk_en) begin
        for (k = 0; k < 2; k = k + 1) begin
            pk_d_r[k] <= cdsu_pick(pck_cfg_r[k][1:0], src_s);
            if (cdsu_pick(pck_cfg_r[k][1:0], src_s) != pk_d_r[k] &&
                cdsu_output_divider_select_div(pck_cfg_r[k][4:2]) != 7'h00) begin
                if (pk_cnt_r[k] + 7'h01 >= cdsu_output_divider_select_div(pck_cfg_r[k][4:2])) begin
                    pk_cnt_r[k] <= 7'h00;
                    prog_clk[k] <= ~prog_clk[k];
                end else begin
                    pk_cnt_r[k] <= pk_cnt_r[k] + 7'h01;
                end
            end
        end
    end
end

// ----------------------------------------------------------------
// ready flags: drop on a config write, rise after a short settle
// ----------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        mck_rdy_r <= 1'b1;
        pck_rdy_r <= 2'h3;
        rdy_tmr_r <= 4'h0;
    end else if (clk_en) begin
        if (wr_hit_mck || (reg_wr && reg_addr == `CDSU_PCK0_CFG) ||
            (reg_wr && reg_addr == `CDSU_PCK1_CFG)) begin
            rdy_tmr_r <= 4'hf;
            if (wr_hit_mck)
                mck_rdy_r <= 1'b0;
            if (reg_addr == `CDSU_PCK0_CFG)
                pck_rdy_r[0] <= 1'b0;
            if (reg_addr == `CDSU_PCK1_CFG)
                pck_rdy_r[1] <= 1'b0;
        end else if (rdy_tmr_r != 4'h0) begin
            rdy_tmr_r <= rdy_tmr_r - 4'h1;
        end else begin
            mck_rdy_r <= 1'b1;
            pck_rdy_r <= 2'h3;
        end
    end
end

// level interrupt: any enabled status bit that reads one
assign irq = |(status & mask_r);

endmodule // cdsu_clock_unit

// ---- test/cdsu_clock_unit_assertions.sv ----
/*
 * checker for the clock divider and status unit: read port, mask,
 * pump setting and interrupt line, seen only at the top ports.
 * assumes one clock, clk_sys, and the synchronous active-low rst_n.
 */
`timescale 1ns/10ps
`include "cdsu_defs.vh"

module cdsu_clock_unit_checker #(
    parameter CNT_W = 6
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire [1:0] first_pll_pump_current_out,
    input wire irq
);
    // ----------------------------------------------------------------
    // one domain, so clock and disable are given once
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // read data only in the cycle after a read, zero elsewhere
    chk_rdata_idle: assert property (
        clk_en && $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    // write-only places and unmapped ones from the pump offset up read back as zero
    chk_wo_zero: assert property (
        reg_rd && clk_en && (reg_addr == `CDSU_IRQ_EN || reg_addr == `CDSU_IRQ_DIS
        || reg_addr >= `CDSU_PUMP) |=> reg_rdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    chk_mask_bits: assert property (
        reg_rd && clk_en && reg_addr == `CDSU_IRQ_MASK
        |=> reg_rdata[31:10] == 22'h0 && reg_rdata[7:4] == 4'h0)
        else $error("mask shows bits outside its fields");
    chk_status_bits: assert property (
        reg_rd && clk_en && reg_addr == `CDSU_STATUS
        |=> reg_rdata[31:10] == 22'h0 && reg_rdata[6:4] == 3'h0)
        else $error("status shows reserved bits");
    // master code zero must leave the processor bit cleared
    chk_processor_clock_divider_forced: assert property (
        reg_wr && clk_en && reg_addr == `CDSU_MCK_CFG && reg_wdata[9:8] == 2'b00
        ##1 reg_rd && clk_en && reg_addr == `CDSU_MCK_CFG |=> !reg_rdata[12])
        else $error("processor divide bit kept with master code zero");
    chk_pump_store: assert property (
        reg_wr && clk_en && reg_addr == `CDSU_PUMP
        |=> first_pll_pump_current_out == {$past(reg_wdata[16]), $past(reg_wdata[0])})
        else $error("pump setting not taken from the write");
    // disabling every source must drop the line at once
    chk_irq_drop: assert property (
        reg_wr && clk_en && reg_addr == `CDSU_IRQ_DIS && reg_wdata[9:8] == 2'b11
        && reg_wdata[3:0] == 4'hf |=> !irq)
        else $error("interrupt still high with every source disabled");
    chk_mask_set: assert property (
        reg_wr && clk_en && reg_addr == `CDSU_IRQ_EN ##1 reg_rd && clk_en
        && reg_addr == `CDSU_IRQ_MASK |=> (reg_rdata[9:0] & $past(reg_wdata[9:0], 2)
        & 10'h30f) == ($past(reg_wdata[9:0], 2) & 10'h30f))
        else $error("enabled source missing from the mask");
    chk_irq_none: assert property (
        reg_rd && clk_en && reg_addr == `CDSU_IRQ_MASK ##1 reg_rdata[9:0] == 10'h0
        |-> !irq)
        else $error("interrupt high with an empty mask");
endmodule // cdsu_clock_unit_checker

bind cdsu_clock_unit cdsu_clock_unit_checker #(.CNT_W(CNT_W)) i_cdsu_clock_unit_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_pll_pump_current_out(first_pll_pump_current_out), .irq(irq));

// ---- test/cdsu_clock_unit_tb.sv ----
/*
 * bench for the clock divider and status unit: register tasks and
 * output period probes against source pins made from clk_sys.
 * assumes the checker file is compiled before it and binds itself.
 */
`timescale 1ns/10ps
`include "cdsu_defs.vh"
`define check_eq(got, exp) begin n_compared = n_compared + 1; \
    if ((got) !== (exp)) begin err_total = err_total + 1; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); end end

module cdsu_clock_unit_tb;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg clk_en = 1'b1; // dropped once to check that state freezes
    reg held = 1'b0; // programmable output level before a stop
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [3:0] src = 4'h0; // slow, main, pll1, pll2 pins
    reg slow_sel = 1'b0;
    reg slow_run = 1'b0; // slow pin still so lock bits stay low early
    reg [31:0] rd_exp = 32'h0, rd_msk = 32'h0, due_exp = 32'h0, due_msk = 32'h0;
    reg rd_due = 1'b0;
    wire [31:0] reg_rdata;
    wire master_clk, processor_clk, irq;
    wire [1:0] prog_clk, pump;
    wire [3:0] outs = {prog_clk, processor_clk, master_clk};
    integer err_total = 0, n_compared = 0, tick = 0, k, i;

    cdsu_clock_unit #(.CNT_W(6)) i_cdsu_clock_unit (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk_in(src[0]), .main_clk_in(src[1]),
        .pll1_clk_in(src[2]), .pll2_clk_in(src[3]), .slow_source_choice(slow_sel),
        .master_clk(master_clk), .processor_clk(processor_clk), .prog_clk(prog_clk),
        .first_pll_pump_current_out(pump), .irq(irq));

    always #10 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // source pins: half periods 8, 5, 6, 7 clocks; cut a hang short
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        tick <= tick + 1;
        for (k = 0; k < 4; k = k + 1)
            if ((k > 0 || slow_run) && tick % (k == 0 ? 8 : k + 4) == 0)
                src[k] <= ~src[k];
        if (tick == 60000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end

    // read answer is looked at in the one cycle it stands
    always @(posedge clk_sys) begin
        if (rd_due)
            `check_eq(reg_rdata & due_msk, due_exp)
        rd_due <= reg_rd;
        due_exp <= rd_exp;
        due_msk <= rd_msk;
    end

    // ----------------------------------------------------------------
    // bus tasks: strobes stay up across back-to-back calls
    // ----------------------------------------------------------------
    task wr(input [7:0] a, input [31:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            reg_rd <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            reg_addr <= a;
            rd_msk <= m;
            rd_exp <= e;
            reg_rd <= 1'b1;
            reg_wr <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task idle(input integer n);
        begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            repeat (n) @(posedge clk_sys);
        end
    endtask

    // period between the second and third rise, first ones may be torn
    task measure(input [1:0] w, input integer e);
        integer c, r, gap;
        reg prv;
        begin
            c = 0;
            r = 0;
            gap = 0;
            prv = 1'b1;
            while (r < 3 && c < 5000) begin
                @(posedge clk_sys);
                c = c + 1;
                gap = gap + 1;
                if (outs[w] && !prv) begin
                    r = r + 1;
                    if (r < 3)
                        gap = 0;
                end
                prv = outs[w];
            end
            `check_eq(gap, e)
        end
    endtask

    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(`CDSU_STATUS, 32'hffffffff, 32'h308);
        slow_sel <= 1'b1;
        idle(6);
        rd(`CDSU_STATUS, 32'h80, 32'h80);
        wr(`CDSU_IRQ_EN, 32'hffffffff);
        rd(`CDSU_IRQ_MASK, 32'hffffffff, 32'h30f);
        idle(1);
        `check_eq(irq, 1'b1)
        wr(`CDSU_IRQ_EN, 32'h0);
        wr(`CDSU_IRQ_DIS, 32'h308);
        rd(`CDSU_IRQ_MASK, 32'hffffffff, 32'h007);
        idle(1);
        `check_eq(irq, 1'b0)
        wr(`CDSU_IRQ_DIS, 32'h3ff);
        rd(`CDSU_IRQ_MASK, 32'hffffffff, 32'h0);
        rd(`CDSU_IRQ_EN, 32'hffffffff, 32'h0);
        rd(`CDSU_IRQ_DIS, 32'hffffffff, 32'h0);
        rd(`CDSU_PUMP, 32'hffffffff, 32'h0);
        rd(8'h3c, 32'hffffffff, 32'h0);
        wr(`CDSU_PUMP, 32'h1);
        idle(1);
        `check_eq(pump, 2'b01)
        wr(`CDSU_MCK_CFG, 32'h1001);
        rd(`CDSU_MCK_CFG, 32'h131f, 32'h0001);
        // freeze: the read answer must stand while clk_en is low
        clk_en <= 1'b0;
        idle(3);
        `check_eq(reg_rdata, 32'h00000001)
        clk_en <= 1'b1;
        idle(1);
        measure(1, 10);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`CDSU_MCK_CFG, {22'h0, i[1:0], 8'h01});
            rd(`CDSU_STATUS, 32'h8, 32'h0);
            idle(1);
            measure(0, 10 * (i == 3 ? 6 : 1 << i));
            rd(`CDSU_STATUS, 32'h8, 32'h8);
        end
        wr(`CDSU_MCK_CFG, 32'h1101);
        idle(1);
        measure(1, 20);
        for (i = 0; i < 7; i = i + 1) begin
            wr(`CDSU_PCK0_CFG, {27'h0, i[2:0], 2'b01});
            rd(`CDSU_STATUS, 32'h100, 32'h0);
            idle(1);
            measure(2, 10 << i);
            rd(`CDSU_STATUS, 32'h100, 32'h100);
        end
        // reserved prescaler code: the output must stop where it is
        wr(`CDSU_PCK0_CFG, 32'h1d);
        idle(2);
        held = prog_clk[0];
        idle(100);
        `check_eq(prog_clk[0], held)
        slow_run <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`CDSU_PCK1_CFG, i);
            idle(1);
            measure(3, i == 0 ? 16 : 2 * i + 8);
        end
        rd(`CDSU_STATUS, 32'h200, 32'h200);
        wr(`CDSU_OSC_CTRL, 32'h0101);
        rd(`CDSU_STATUS, 32'h1, 32'h0);
        idle(40);
        rd(`CDSU_STATUS, 32'h1, 32'h0);
        idle(400);
        rd(`CDSU_STATUS, 32'h1, 32'h1);
        wr(`CDSU_PLL1_CFG, 32'h0400);
        wr(`CDSU_PLL2_CFG, 32'h0400);
        rd(`CDSU_STATUS, 32'h6, 32'h0);
        idle(40);
        rd(`CDSU_STATUS, 32'h6, 32'h0);
        idle(200);
        rd(`CDSU_STATUS, 32'h6, 32'h6);
        wr(`CDSU_IRQ_EN, 32'h2);
        idle(1);
        `check_eq(irq, 1'b1)
        idle(2);
        complete_run;
    end
endmodule // cdsu_clock_unit_tb
